// *** rtl/bus_transceiver.sv ***
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps


module bus_transceiver
  import xcvr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`XCVR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`XCVR_BUS_W-1:0] avs_writedata,
  input wire logic [`XCVR_BE_W-1:0] avs_byteenable,
  output logic [`XCVR_BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [`XCVR_DATA_W-1:0] card_input,
  output logic [`XCVR_DATA_W-1:0] card_output,
  output logic [`XCVR_DATA_W-1:0] card_output_oe,
  input wire logic [`XCVR_DATA_W-1:0] backplane_in,
  output logic [`XCVR_DATA_W-1:0] backplane_out,
  output logic [`XCVR_DATA_W-1:0] backplane_oe,
  input wire logic forward_capture_strobe,
  input wire logic return_capture_strobe,
  output logic slow_edge_rate
);

  xcvr_state_t state;
  xcvr_state_t next_state;
  avm_req_t req;
  logic [`XCVR_DATA_W-1:0] forward_out;
  logic [`XCVR_DATA_W-1:0] return_in;
  logic [`XCVR_DATA_W-1:0] return_out;
  logic backplane_active;

  // ========================================================================
  // Bus request bundle
  // ========================================================================
  // Gathers the slave inputs into one carrier.
  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;
  assign req.byteenable = avs_byteenable;

  // ========================================================================
  // Data path elements
  // ========================================================================
  // Card-to-backplane element, fed straight from the card input pins.
  logic_element forward_element (
    .sys_clk(sys_clk),
    .mode({state.ctrl.forward_mode_hi, state.ctrl.forward_mode_lo}),
    .strobe(forward_capture_strobe),
    .data_in(card_input),
    .data_out(forward_out)
  );

  // Return input source: backplane wire level or the forward element.
  assign return_in = state.ctrl.loopback ? forward_out : backplane_in;

  // Backplane-to-card element.
  logic_element return_element (
    .sys_clk(sys_clk),
    .mode({state.ctrl.return_mode_hi, state.ctrl.return_mode_lo}),
    .strobe(return_capture_strobe),
    .data_in(return_in),
    .data_out(return_out)
  );

  // Backplane is active only for the one legal enable combination.
  assign backplane_active = state.ctrl.backplane_enable
    && !state.ctrl.backplane_enable_n;

  // ========================================================================
  // Next-state logic
  // ========================================================================
  // Drives the pins from the elements and runs the register handshake.
  always_comb
  begin
    next_state = state;

    // Card outputs carry the return element and float when disabled.
    next_state.card_output = return_out;
    next_state.card_output_oe =
      {`XCVR_DATA_W{state.ctrl.card_output_enable}};

    // Open-drain backplane pulls low only where the forward data is low.
    next_state.backplane_oe =
      {`XCVR_DATA_W{backplane_active}} & ~forward_out;

    // Slope select level reaches the edge-rate pin one clock later, through the state register.
    next_state.slow_edge_rate = state.ctrl.slope_select;

    case (state.bus)
      bus_idle:
      begin
        next_state.rsp.waitrequest = 1'b1;
        if (req.read || req.write)
        begin
          next_state.rsp.readdata = '0;
          if (req.read && req.address == `XCVR_CTRL_ADDR)
          begin
            next_state.rsp.readdata[`XCVR_CTRL_W-1:0] = state.ctrl;
          end
          else if (req.read && req.address == `XCVR_STATUS_ADDR)
          begin
            next_state.rsp.readdata[`XCVR_STAT_FWD_LSB +: `XCVR_DATA_W] =
              forward_out;
            next_state.rsp.readdata[`XCVR_STAT_RET_LSB +: `XCVR_DATA_W] =
              return_out;
            next_state.rsp.readdata[`XCVR_STAT_FWD_STROBE] =
              forward_capture_strobe;
            next_state.rsp.readdata[`XCVR_STAT_RET_STROBE] =
              return_capture_strobe;
          end
          next_state.rsp.waitrequest = 1'b0;
          next_state.bus = bus_answer;
        end
      end
      bus_answer:
      begin
        // The master samples waitrequest low at this edge; writes land here.
        if (req.write && req.address == `XCVR_CTRL_ADDR)
        begin
          if (req.byteenable[0])
          begin
            next_state.ctrl.forward_mode_lo =
              req.writedata[`XCVR_CTRL_FWD_MODE_LO];
            next_state.ctrl.forward_mode_hi =
              req.writedata[`XCVR_CTRL_FWD_MODE_HI];
            next_state.ctrl.return_mode_lo =
              req.writedata[`XCVR_CTRL_RET_MODE_LO];
            next_state.ctrl.return_mode_hi =
              req.writedata[`XCVR_CTRL_RET_MODE_HI];
            next_state.ctrl.loopback = req.writedata[`XCVR_CTRL_LOOPBACK];
            next_state.ctrl.card_output_enable =
              req.writedata[`XCVR_CTRL_CARD_OE];
            next_state.ctrl.backplane_enable =
              req.writedata[`XCVR_CTRL_BP_EN];
            next_state.ctrl.backplane_enable_n =
              req.writedata[`XCVR_CTRL_BP_EN_N];
          end
          if (req.byteenable[1])
          begin
            next_state.ctrl.slope_select = req.writedata[`XCVR_CTRL_SLOPE];
          end
        end
        next_state.rsp.waitrequest = 1'b1;
        next_state.bus = bus_idle;
      end
      default:
      begin
        next_state.rsp.waitrequest = 1'b1;
        next_state.bus = bus_idle;
      end
    endcase
  end

  // ========================================================================
  // State register
  // ========================================================================
  // Control and pin state reset; element storage lives in the elements.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state.bus <= bus_idle;
      state.ctrl <= `XCVR_CTRL_RESET;
      state.rsp.readdata <= '0;
      state.rsp.waitrequest <= 1'b1;
      state.card_output <= '0;
      state.card_output_oe <= '0;
      state.backplane_oe <= '0;
      state.slow_edge_rate <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // Outputs come from the state register except backplane_out, tied low; open drain never drives high.
  assign avs_readdata = state.rsp.readdata;
  assign avs_waitrequest = state.rsp.waitrequest;
  assign card_output = state.card_output;
  assign card_output_oe = state.card_output_oe;
  assign backplane_out = '0;
  assign backplane_oe = state.backplane_oe;
  assign slow_edge_rate = state.slow_edge_rate;

endmodule // bus_transceiver

// *** pkg/xcvr_map.svh ***
`ifndef XCVR_MAP_SVH
`define XCVR_MAP_SVH

// ==========================================================================
// Data path width
// ==========================================================================
`define XCVR_DATA_W 8

// ==========================================================================
// Register bus geometry and byte addresses
// ==========================================================================
`define XCVR_ADDR_W 4
`define XCVR_BUS_W 32
`define XCVR_BE_W 4
`define XCVR_CTRL_ADDR 4'h0
`define XCVR_STATUS_ADDR 4'h4

// ==========================================================================
// Control register field positions
// ==========================================================================
`define XCVR_CTRL_FWD_MODE_LO 0
`define XCVR_CTRL_FWD_MODE_HI 1
`define XCVR_CTRL_RET_MODE_LO 2
`define XCVR_CTRL_RET_MODE_HI 3
`define XCVR_CTRL_LOOPBACK 4
`define XCVR_CTRL_CARD_OE 5
`define XCVR_CTRL_BP_EN 6
`define XCVR_CTRL_BP_EN_N 7
`define XCVR_CTRL_SLOPE 8
`define XCVR_CTRL_W 9
`define XCVR_CTRL_RESET 9'h080

// ==========================================================================
// Status register field positions
// ==========================================================================
`define XCVR_STAT_FWD_LSB 0
`define XCVR_STAT_RET_LSB 8
`define XCVR_STAT_FWD_STROBE 16
`define XCVR_STAT_RET_STROBE 17

// ==========================================================================
// Mode field encodings
// ==========================================================================
`define XCVR_MODE_BUFFER 2'h0
`define XCVR_MODE_FLOP 2'h1

`endif

// *** pkg/xcvr_pkg.sv ***
`include "xcvr_map.svh"

package xcvr_pkg;

  // ========================================================================
  // Logic element kinds, one-hot.
  // ========================================================================
  typedef enum logic [2:0] {
    elem_buffer = 3'h1,
    elem_flop = 3'h2,
    elem_latch = 3'h4
  } element_kind_t;

  // ========================================================================
  // Register bus handshake states, one-hot.
  // ========================================================================
  typedef enum logic [1:0] {
    bus_idle = 2'h1,
    bus_answer = 2'h2
  } bus_state_t;

  // ========================================================================
  // Software control fields.
  // ========================================================================
  typedef struct packed {
    logic slope_select;
    logic backplane_enable_n;
    logic backplane_enable;
    logic card_output_enable;
    logic loopback;
    logic return_mode_hi;
    logic return_mode_lo;
    logic forward_mode_hi;
    logic forward_mode_lo;
  } ctrl_t;

  // ========================================================================
  // Avalon-MM slave signals.
  // ========================================================================
  typedef struct packed {
    logic [`XCVR_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [`XCVR_BUS_W-1:0] writedata;
    logic [`XCVR_BE_W-1:0] byteenable;
  } avm_req_t;

  typedef struct packed {
    logic [`XCVR_BUS_W-1:0] readdata;
    logic waitrequest;
  } avm_rsp_t;

  // ========================================================================
  // State of one logic element; it carries no reset.
  // ========================================================================
  typedef struct packed {
    logic [`XCVR_DATA_W-1:0] held;
    logic strobe_prev;
  } element_state_t;

  // ========================================================================
  // State of the transceiver top.
  // ========================================================================
  typedef struct packed {
    bus_state_t bus;
    ctrl_t ctrl;
    avm_rsp_t rsp;
    logic [`XCVR_DATA_W-1:0] card_output;
    logic [`XCVR_DATA_W-1:0] card_output_oe;
    logic [`XCVR_DATA_W-1:0] backplane_oe;
    logic slow_edge_rate;
  } xcvr_state_t;

  // Decodes a two-bit mode field; a high upper bit always means latch.
  function automatic element_kind_t decode_mode(input logic [1:0] mode);
    element_kind_t kind;
    kind = elem_latch;
    if (mode == `XCVR_MODE_BUFFER)
    begin
      kind = elem_buffer;
    end
    else if (mode == `XCVR_MODE_FLOP)
    begin
      kind = elem_flop;
    end
    return kind;
  endfunction

endpackage

// *** rtl/logic_element.sv ***
`timescale 1ns/100ps

module logic_element
  import xcvr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [1:0] mode,
  input wire logic strobe,
  input wire logic [`XCVR_DATA_W-1:0] data_in,
  output logic [`XCVR_DATA_W-1:0] data_out
);

  element_state_t state;
  element_state_t next_state;
  element_kind_t kind;

  // Decodes the mode field once for both the output and the update.
  assign kind = decode_mode(mode);

  // ========================================================================
  // Output selection
  // ========================================================================
  // Buffer passes through, flop shows the held value, latch is transparent
  // while the strobe is high.
  always_comb
  begin
    case (kind)
      elem_buffer: data_out = data_in;
      elem_flop: data_out = state.held;
      elem_latch: data_out = strobe ? data_in : state.held;
      default: data_out = data_in;
    endcase
  end

  // ========================================================================
  // Storage update
  // ========================================================================
  // Storage keeps working no matter whether the outputs are enabled.
  always_comb
  begin
    next_state = state;
    next_state.strobe_prev = strobe;
    case (kind)
      elem_flop:
      begin
        if (strobe && !state.strobe_prev)
        begin
          next_state.held = data_in;
        end
      end
      elem_latch:
      begin
        if (strobe)
        begin
          next_state.held = data_in;
        end
      end
      default:
      begin
        next_state.held = state.held;
      end
    endcase
  end

  // Storage has no reset, so contents are unknown until first capture.
  always_ff @(posedge sys_clk)
  begin
    state <= next_state;
  end

endmodule // logic_element

// *** bench/backplane_model.sv ***
`timescale 1ns/100ps

// ==========================================================
// Shared backplane with a pull-up and one remote card.
module backplane_model
  import xcvr_pkg::*;
(
  input wire logic [7:0] backplane_oe,
  input wire logic [7:0] remote_pull,
  output logic [7:0] backplane_in
);
  // A line is low while any card pulls it, else the pull-up wins.
  assign backplane_in = ~(backplane_oe | remote_pull);
endmodule // backplane_model

// *** bench/bus_transceiver_asserts.sv ***
`timescale 1ns/100ps

// ==========================================================
// Port checker for the transceiver.
module bus_transceiver_asserts
  import xcvr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] card_input,
  input wire logic [7:0] card_output,
  input wire logic [7:0] card_output_oe,
  input wire logic [7:0] backplane_in,
  input wire logic [7:0] backplane_out,
  input wire logic [7:0] backplane_oe,
  input wire logic forward_capture_strobe,
  input wire logic return_capture_strobe,
  input wire logic slow_edge_rate
);
  logic [8:0] c;
  logic run;
  logic wr;
  logic fbuf;
  logic fhold;
  logic rhold;

  // Shadow control word; a write lands when waitrequest is low.
  assign wr = avs_write && !avs_waitrequest && avs_address == 4'h0;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      c <= 9'h080;
      run <= 1'b0;
    end
    else
    begin
      run <= 1'b1;
      if (wr && avs_byteenable[0])
        c[7:0] <= avs_writedata[7:0];
      if (wr && avs_byteenable[1])
        c[8] <= avs_writedata[8];
    end
  end

  // Conditions where an element passes or must hold its value.
  assign fbuf = c[1:0] == 2'h0 && c[6] && !c[7];
  assign fhold = c[1] && c[6] && !c[7] && !forward_capture_strobe;
  assign rhold = c[3:2] == 2'h1 && !return_capture_strobe;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n || !run);

  // ==========================================================
  // Assertions.
  a_card_oe: assert property (card_output_oe == {8{$past(c[5])}})
    else $error("card enable mismatch");
  a_bp_pair: assert property (|backplane_oe |-> $past(c[6] && !c[7]))
    else $error("backplane driven while disabled");
  a_slope: assert property (slow_edge_rate == $past(c[8]))
    else $error("edge rate mismatch");
  a_fwd_buffer: assert property ($past(fbuf) |->
    backplane_oe == ~$past(card_input))
    else $error("forward buffer mismatch");
  a_ret_buffer: assert property ($past(c[4:2] == 3'h0) |->
    card_output == $past(backplane_in))
    else $error("return buffer mismatch");
  a_loop_buf: assert property ($past(c[4:0] == 5'h10) |->
    card_output == $past(card_input))
    else $error("loopback mismatch");
  a_fwd_hold: assert property ($past(fhold, 2) && $past(fhold) |->
    $stable(backplane_oe))
    else $error("latch did not hold");
  a_ret_hold: assert property ($past(rhold, 2) && $past(rhold) |->
    $stable(card_output))
    else $error("flop did not hold");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule // bus_transceiver_asserts

// *** bench/bus_transceiver_bench.sv ***
`timescale 1ns/100ps

// ==========================================================
// Self-checking bench for the transceiver.
module bus_transceiver_bench
  import xcvr_pkg::*;
;
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] card_input, card_output, card_output_oe, backplane_in;
  logic [7:0] backplane_out, backplane_oe, remote_pull;
  logic forward_capture_strobe, return_capture_strobe, slow_edge_rate;
  logic [7:0] fh, rh, fo, ri, ro;
  logic fsp, rsp;
  logic [8:0] m;
  logic [24:0] ex;
  int err_total, n_checks;

  bus_transceiver bus_transceiver_i (.sys_clk, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .card_input, .card_output, .card_output_oe,
    .backplane_in, .backplane_out, .backplane_oe, .forward_capture_strobe,
    .return_capture_strobe, .slow_edge_rate);
  backplane_model backplane_model_i (.backplane_oe, .remote_pull,
    .backplane_in);

  // Free-running clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Tasks.
  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    if (!$isunknown(e))
    begin
      n_checks++;
      if (s !== e)
      begin
        err_total++;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
      end
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] r);
    int n;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
    if (n == 40)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      end_of_test();
    end
  endtask

  // Reference model: checks the last edge's outputs, then steps.
  always @(posedge sys_clk)
  begin
    if (!arst_n)
    begin
      m = 9'h080;
      ex = '0;
    end
    else
    begin
      check({24'h0, card_output}, {24'h0, ex[24:17]});
      check({24'h0, card_output_oe}, {24'h0, ex[16:9]});
      check({24'h0, backplane_oe}, {24'h0, ex[8:1]});
      check({31'h0, slow_edge_rate}, {31'h0, ex[0]});
      check({24'h0, backplane_out}, 32'h0);
      fo = m[1] ? (forward_capture_strobe ? card_input : fh) :
        (m[0] ? fh : card_input);
      ri = m[4] ? fo : backplane_in;
      ro = m[3] ? (return_capture_strobe ? ri : rh) : (m[2] ? rh : ri);
      if (m[1] ? forward_capture_strobe : m[0] && forward_capture_strobe && !fsp)
        fh = card_input;
      if (m[3] ? return_capture_strobe : m[2] && return_capture_strobe && !rsp)
        rh = ri;
      fsp = forward_capture_strobe;
      rsp = return_capture_strobe;
      ex = {ro, {8{m[5]}}, (m[6] && !m[7]) ? ~fo : 8'h00, m[8]};
      if (avs_write && !avs_waitrequest && avs_address == 4'h0)
        m = {avs_byteenable[1] ? avs_writedata[8] : m[8],
          avs_byteenable[0] ? avs_writedata[7:0] : m[7:0]};
    end
  end

  // ==========================================================
  // Main sequence.
  initial
  begin
    arst_n = 1'b0;
    {avs_read, avs_write, forward_capture_strobe, return_capture_strobe} = '0;
    {avs_address, avs_byteenable, avs_writedata, card_input, remote_pull} = '0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'he596));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    card_input <= 8'h5A;
    @(posedge sys_clk);
    bus(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h080);
    bus(1'b1, 4'h8, 32'h1FF, 4'hF, q);
    bus(1'b0, 4'h8, 32'h0, 4'hF, q);
    check(q, 32'h0);
    bus(1'b1, 4'h4, 32'h1FF, 4'hF, q);
    bus(1'b1, 4'h0, 32'h1FF, 4'h2, q);
    bus(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h180);
    bus(1'b0, 4'h4, 32'h0, 4'hF, q);
    check(q, 32'h0000FF5A);
    bus(1'b1, 4'h0, 32'h08A, 4'h3, q);
    {forward_capture_strobe, return_capture_strobe} <= 2'h3;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 64; i++)
    begin
      bus(1'b1, 4'h0, ($urandom << 6) | 32'(i), 4'h3, q);
      repeat (20)
      begin
        @(posedge sys_clk);
        card_input <= 8'($urandom);
        remote_pull <= 8'($urandom) & 8'($urandom) & 8'($urandom);
        {forward_capture_strobe, return_capture_strobe} <= 2'($urandom);
      end
    end
    end_of_test();
  end
endmodule // bus_transceiver_bench

bind bus_transceiver bus_transceiver_asserts bus_transceiver_asserts_i (
  .sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .card_input,
  .card_output, .card_output_oe, .backplane_in, .backplane_out,
  .backplane_oe, .forward_capture_strobe, .return_capture_strobe,
  .slow_edge_rate);
